// ===== rtl/adcc_defs.svh
// constants of the six-channel converter control block
// assumes inclusion by bare name from the design files
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define ADCC_OFF_STATUS 8'h00
`define ADCC_OFF_CTRL 8'h04
`define ADCC_OFF_CONV_TIME 8'h08
`define ADCC_OFF_SAMPLE0 8'h10
`define ADCC_OFF_SAMPLE5 8'h24

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ADCC_ST_BUSY_POS 0
`define ADCC_ST_STANDBY_N_POS 1
`define ADCC_ST_RANGE_LSB 2
`define ADCC_ST_PWRDN_LSB 5
`define ADCC_ST_ARMED_LSB 8
`define ADCC_CTRL_RNG_LSB 2
`define ADCC_CTRL_SEL_LSB 5

// ---------------------------------------------------------------
// reset values, counts and lane masks
// ---------------------------------------------------------------
`define ADCC_CTRL_RST 8'h00
`define ADCC_CONV_TIME_RST 16'h0020
`define ADCC_PIN_RST 14'h1C0F
`define ADCC_PD_CYCLES 64
`define ADCC_BYTE_MASK 16'hFF00
`define ADCC_WORD_MASK 16'hFFFF

`endif

// ===== rtl/adcc_pkg.sv
// types of the six-channel converter control block
// assumes adcc_defs.svh is compiled alongside
package adcc_pkg;

  typedef enum logic [1:0] {
    ADCC_ST_IDLE,
    ADCC_ST_CONV,
    ADCC_ST_STORE
  } adcc_state_t;

endpackage

// ===== rtl/adcc_mem.sv
// result memory: one write port, registered read port
// assumes one clock, asynchronous active-low reset, clock enable
`timescale 1ns/1ps
module adcc_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 6,
  parameter int AW = 3
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (ce_in && we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // ---------------------------------------------------------------
  // registered read
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_out <= '0;
    end else if (ce_in) begin
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule

// ===== rtl/adcc_top.sv
// control logic of a six-channel simultaneous-sampling converter
// assumes pins are asynchronous to SYS_CLK_IN; apb master on same clock
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`include "adcc_defs.svh"

module adcc_top #(
  parameter int CH_W = 16,
  parameter int N_CH = 6,
  parameter int PD_CYCLES = `ADCC_PD_CYCLES
) (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic CE_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic PAIR_START_A_IN,
  input wire logic PAIR_START_B_IN,
  input wire logic PAIR_START_C_IN,
  input wire logic STANDBY_N_IN,
  input wire logic RANGE_IN,
  input wire logic RESET_IN,
  input wire logic HW_SW_SELECT_IN,
  input wire logic SERIAL_PARALLEL_SEL_IN,
  input wire logic WORD_BYTE_SEL_IN,
  input wire logic BYTE_ORDER_SEL_IN,
  input wire logic CS_N_IN,
  input wire logic RD_N_IN,
  input wire logic WR_N_IN,
  input wire logic SCLK_IN,
  input wire logic [15:0] DB_IN,
  output logic [15:0] DB_OUT,
  output logic [15:0] DB_OE_OUT,
  output logic DOUT_A_OUT,
  output logic BUSY_OUT,
  output logic [2:0] PAIR_HOLD_OUT,
  output logic [2:0] PAIR_PWRDN_OUT
);
  import adcc_pkg::*;

  localparam int NPIN = 14;

  logic [NPIN-1:0] pin_raw, pin_m, pin_s, pin_p;
  logic [7:0] db_m, db_s;
  logic [2:0] start_s, start_p, rise, armed_q, pd_q, go_mask, hw_req;
  logic standby_n_s, range_s, dev_rst, hw_sw_s, ser_s, par_s, wb_s, order_s;
  logic cs_n_s, rd_n_s, wr_n_s, cs_fall, rd_rise, sclk_fall, start_ok;
  logic [7:0] ctrl_q;
  logic [15:0] conv_time_q, conv_cnt_q;
  logic [CH_W-1:0] sample_q [N_CH];
  adcc_state_t state_q;
  logic [2:0] mask_q, ch_q, rd_ptr_q;
  logic [2:0] range_q, eff_range;
  logic store_end, mem_we;
  logic [CH_W-1:0] mem_wdata, mem_rdata, sel_sample;
  logic byte_ph_q, sel_hi, drive;
  logic [CH_W-1:0] sh_q, dbo_q;
  logic [3:0] bit_q;
  logic [1:0] reload_q;
  logic setup, access, mapped, is_sample;
  logic [2:0] samp_idx;
  logic [31:0] prdata_q, rd_word;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  assign pin_raw = {SCLK_IN, WR_N_IN, RD_N_IN, CS_N_IN, BYTE_ORDER_SEL_IN,
                    WORD_BYTE_SEL_IN, SERIAL_PARALLEL_SEL_IN, HW_SW_SELECT_IN,
                    RESET_IN, RANGE_IN, STANDBY_N_IN, PAIR_START_C_IN,
                    PAIR_START_B_IN, PAIR_START_A_IN};

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      pin_m <= `ADCC_PIN_RST;
      pin_s <= `ADCC_PIN_RST;
      pin_p <= `ADCC_PIN_RST;
      db_m <= 8'h00;
      db_s <= 8'h00;
    end else if (CE_IN) begin
      pin_m <= pin_raw;
      pin_s <= pin_m;
      pin_p <= pin_s;
      db_m <= DB_IN[15:8];
      db_s <= db_m;
    end
  end

  assign start_s = pin_s[2:0];
  assign start_p = pin_p[2:0];
  assign standby_n_s = pin_s[3];
  assign range_s = pin_s[4];
  assign dev_rst = pin_s[5];
  assign hw_sw_s = pin_s[6];
  assign ser_s = pin_s[7];
  assign par_s = ~pin_s[7];
  assign wb_s = pin_s[8];
  assign order_s = pin_s[9];
  assign cs_n_s = pin_s[10];
  assign rd_n_s = pin_s[11];
  assign wr_n_s = pin_s[12];
  assign cs_fall = ~cs_n_s & pin_p[10];
  assign rd_rise = rd_n_s & ~pin_p[11] & ~cs_n_s;
  assign sclk_fall = ~pin_s[13] & pin_p[13] & ~cs_n_s & ser_s;

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      ctrl_q <= `ADCC_CTRL_RST;
    end else if (CE_IN) begin
      if (dev_rst) begin
        ctrl_q <= `ADCC_CTRL_RST;
      end else if (par_s && !cs_n_s && !wr_n_s) begin
        ctrl_q <= db_s;
      end
    end
  end

  // ---------------------------------------------------------------
  // per-pair start edges, arming and power-down
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_pair
      logic [15:0] low_cnt_q;
      assign rise[p] = start_s[p] & ~start_p[p];
      assign hw_req[p] = rise[p] & armed_q[p] & ~pd_q[p];

      always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          armed_q[p] <= 1'b0;
        end else if (CE_IN) begin
          if (dev_rst) begin
            armed_q[p] <= 1'b0;
          end else if (!start_s[p]) begin
            armed_q[p] <= 1'b1;
          end
        end
      end

      always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          low_cnt_q <= 16'h0000;
          pd_q[p] <= 1'b0;
        end else if (CE_IN) begin
          if (dev_rst || start_s[p]) begin
            low_cnt_q <= 16'h0000;
            if (dev_rst || rise[p]) begin
              pd_q[p] <= 1'b0;
            end
          end else if (low_cnt_q == 16'(PD_CYCLES - 1)) begin
            pd_q[p] <= 1'b1;
          end else begin
            low_cnt_q <= low_cnt_q + 16'h0001;
          end
        end
      end
    end
  endgenerate

  // software mode: start a launches the pairs the control register picks
  assign go_mask = hw_sw_s ?
    ((hw_req[0]) ? ctrl_q[`ADCC_CTRL_SEL_LSB +: 3] : 3'b000) :
    hw_req;
  assign start_ok = (state_q == ADCC_ST_IDLE) && standby_n_s && !dev_rst
                    && (go_mask != 3'b000);

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  assign store_end = (state_q == ADCC_ST_STORE) && (ch_q == 3'(N_CH - 1));

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_q <= ADCC_ST_IDLE;
      conv_cnt_q <= 16'h0000;
      mask_q <= 3'b000;
      ch_q <= 3'b000;
    end else if (CE_IN) begin
      if (dev_rst) begin
        state_q <= ADCC_ST_IDLE;
        mask_q <= 3'b000;
      end else begin
        case (state_q)
          ADCC_ST_IDLE: begin
            if (start_ok) begin
              mask_q <= go_mask;
              conv_cnt_q <= 16'h0000;
              state_q <= ADCC_ST_CONV;
            end
          end
          ADCC_ST_CONV: begin
            conv_cnt_q <= conv_cnt_q + 16'h0001;
            if (conv_cnt_q + 16'h0001 >= conv_time_q) begin
              ch_q <= 3'b000;
              state_q <= ADCC_ST_STORE;
            end
          end
          ADCC_ST_STORE: begin
            ch_q <= ch_q + 3'b001;
            if (store_end) begin
              state_q <= ADCC_ST_IDLE;
            end
          end
          default: begin
            state_q <= ADCC_ST_IDLE;
          end
        endcase
      end
    end
  end

  assign BUSY_OUT = (state_q != ADCC_ST_IDLE);
  assign PAIR_HOLD_OUT = BUSY_OUT ? mask_q : 3'b000;
  assign PAIR_PWRDN_OUT = pd_q;

  // ---------------------------------------------------------------
  // range selection
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      range_q <= 3'b000;
    end else if (CE_IN) begin
      if (dev_rst) begin
        range_q <= {3{range_s}};
      end else if (store_end) begin
        range_q <= {3{range_s}};
      end
    end
  end

  assign eff_range = hw_sw_s ? ctrl_q[`ADCC_CTRL_RNG_LSB +: 3] : range_q;
  assign sel_sample = sample_q[ch_q];
  // wide range halves the code of the same input
  assign mem_wdata = eff_range[ch_q[2:1]] ? sel_sample :
                     {sel_sample[CH_W-1], sel_sample[CH_W-1:1]};
  assign mem_we = (state_q == ADCC_ST_STORE) && mask_q[ch_q[2:1]];

  adcc_mem #(.WIDTH(CH_W), .DEPTH(N_CH), .AW(3)) u_mem (
    .clk_in(SYS_CLK_IN),
    .nrst_in(NRST_IN),
    .ce_in(CE_IN),
    .we_in(mem_we),
    .waddr_in(ch_q),
    .wdata_in(mem_wdata),
    .raddr_in(rd_ptr_q),
    .rdata_out(mem_rdata)
  );

  // ---------------------------------------------------------------
  // readout pointer and byte phase
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      rd_ptr_q <= 3'b000;
    end else if (CE_IN) begin
      if (dev_rst || store_end) begin
        rd_ptr_q <= 3'b000;
      end else if ((par_s && rd_rise && (!wb_s || byte_ph_q)) ||
                   (sclk_fall && bit_q == 4'hF)) begin
        rd_ptr_q <= (rd_ptr_q == 3'(N_CH - 1)) ? 3'b000 : rd_ptr_q + 3'b001;
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      byte_ph_q <= 1'b0;
    end else if (CE_IN) begin
      if (dev_rst || cs_fall) begin
        byte_ph_q <= 1'b0;
      end else if (par_s && wb_s && rd_rise) begin
        byte_ph_q <= ~byte_ph_q;
      end
    end
  end

  // ---------------------------------------------------------------
  // parallel data lines
  // ---------------------------------------------------------------
  assign sel_hi = order_s ^ byte_ph_q;

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      dbo_q <= 16'h0000;
    end else if (CE_IN) begin
      if (!wb_s) begin
        dbo_q <= mem_rdata;
      end else if (sel_hi) begin
        dbo_q <= {mem_rdata[15:8], 8'h00};
      end else begin
        dbo_q <= {mem_rdata[7:0], 8'h00};
      end
    end
  end

  assign drive = par_s && !cs_n_s && !rd_n_s;
  assign DB_OUT = dbo_q;
  assign DB_OE_OUT = !drive ? 16'h0000 :
                     (wb_s ? `ADCC_BYTE_MASK : `ADCC_WORD_MASK);

  // ---------------------------------------------------------------
  // serial output
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      sh_q <= 16'h0000;
      bit_q <= 4'h0;
      reload_q <= 2'b00;
    end else if (CE_IN) begin
      reload_q <= {reload_q[0], sclk_fall && (bit_q == 4'hF)};
      if (ser_s && cs_fall) begin
        sh_q <= mem_rdata;
        bit_q <= 4'h0;
      end else if (sclk_fall) begin
        sh_q <= {sh_q[CH_W-2:0], 1'b0};
        bit_q <= bit_q + 4'h1;
      end else if (reload_q[1]) begin
        sh_q <= mem_rdata;
      end
    end
  end

  assign DOUT_A_OUT = sh_q[CH_W-1];

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  assign setup = PSEL_IN && !PENABLE_IN;
  assign access = PSEL_IN && PENABLE_IN;
  assign is_sample = (PADDR_IN >= `ADCC_OFF_SAMPLE0) && (PADDR_IN <= `ADCC_OFF_SAMPLE5)
                     && (PADDR_IN[1:0] == 2'b00);
  assign samp_idx = 3'((PADDR_IN - `ADCC_OFF_SAMPLE0) >> 2);
  assign mapped = is_sample || PADDR_IN == `ADCC_OFF_STATUS ||
                  PADDR_IN == `ADCC_OFF_CTRL || PADDR_IN == `ADCC_OFF_CONV_TIME;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (is_sample) begin
      rd_word[CH_W-1:0] = sample_q[samp_idx];
    end else if (PADDR_IN == `ADCC_OFF_STATUS) begin
      rd_word[`ADCC_ST_BUSY_POS] = BUSY_OUT;
      rd_word[`ADCC_ST_STANDBY_N_POS] = ~standby_n_s;
      rd_word[`ADCC_ST_RANGE_LSB +: 3] = eff_range;
      rd_word[`ADCC_ST_PWRDN_LSB +: 3] = pd_q;
      rd_word[`ADCC_ST_ARMED_LSB +: 3] = armed_q;
    end else if (PADDR_IN == `ADCC_OFF_CTRL) begin
      rd_word[7:0] = ctrl_q;
    end else if (PADDR_IN == `ADCC_OFF_CONV_TIME) begin
      rd_word[15:0] = conv_time_q;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      prdata_q <= 32'h0000_0000;
    end else if (CE_IN && setup) begin
      prdata_q <= PWRITE_IN ? 32'h0000_0000 : rd_word;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      conv_time_q <= `ADCC_CONV_TIME_RST;
    end else if (CE_IN && access && PWRITE_IN && PADDR_IN == `ADCC_OFF_CONV_TIME) begin
      conv_time_q <= (PWDATA_IN[15:0] == 16'h0000) ? 16'h0001 : PWDATA_IN[15:0];
    end
  end

  genvar k;
  generate
    for (k = 0; k < N_CH; k++) begin : g_sample
      always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
          sample_q[k] <= '0;
        end else if (CE_IN && access && PWRITE_IN && is_sample && samp_idx == 3'(k)) begin
          sample_q[k] <= PWDATA_IN[CH_W-1:0];
        end
      end
    end
  endgenerate

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access && !mapped;

endmodule

// ===== sim/adcc_monitor.sv
// port checker of the converter control block
// assumes binding to adcc_top, one clock domain
`timescale 1ns/1ps
module adcc_monitor (
  input wire logic SYS_CLK_IN,
  input wire logic NRST_IN,
  input wire logic PAIR_START_A_IN,
  input wire logic PAIR_START_B_IN,
  input wire logic PAIR_START_C_IN,
  input wire logic STANDBY_N_IN,
  input wire logic RESET_IN,
  input wire logic WORD_BYTE_SEL_IN,
  input wire logic CS_N_IN,
  input wire logic [15:0] DB_OE_OUT,
  input wire logic BUSY_OUT,
  input wire logic [2:0] PAIR_HOLD_OUT,
  input wire logic [2:0] PAIR_PWRDN_OUT
);
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!NRST_IN);
  // ----------------
  // assertions
  // ----------------
  AST_BUSY_MIN: assert property ($rose(BUSY_OUT) |-> BUSY_OUT [*7])
    else $error("busy short");
  AST_BUSY_MAX: assert property ($rose(BUSY_OUT) |-> ##[7:200] !BUSY_OUT)
    else $error("busy stuck");
  AST_START_PIN: assert property ($rose(BUSY_OUT) |-> STANDBY_N_IN &&
      (PAIR_START_A_IN || PAIR_START_B_IN || PAIR_START_C_IN))
    else $error("busy without start");
  AST_HOLD_SET: assert property ($rose(BUSY_OUT) |-> PAIR_HOLD_OUT != 3'b000)
    else $error("no pair held");
  AST_RST_ABORT: assert property (RESET_IN [*5] |-> !BUSY_OUT)
    else $error("reset kept busy");
  AST_RST_PD: assert property (RESET_IN [*5] |-> PAIR_PWRDN_OUT == 3'b000)
    else $error("reset kept power-down");
  AST_OE_WIDTH: assert property (DB_OE_OUT != 16'h0000 |->
      DB_OE_OUT == (WORD_BYTE_SEL_IN ? 16'hFF00 : 16'hFFFF))
    else $error("bad lane enable");
  AST_OE_IDLE: assert property (CS_N_IN && $past(CS_N_IN, 3) |-> DB_OE_OUT == 16'h0000)
    else $error("driven unselected");
  AST_PWRDN: assert property ($rose(PAIR_PWRDN_OUT[1]) |-> !$past(PAIR_START_B_IN, 8))
    else $error("power-down without low start");
  cover property ($rose(BUSY_OUT));
  cover property ($fell(PAIR_PWRDN_OUT[1]));
  cover property (DB_OE_OUT == 16'hFF00);
endmodule
bind adcc_top adcc_monitor u_mon (
  .SYS_CLK_IN(SYS_CLK_IN),
  .NRST_IN(NRST_IN),
  .PAIR_START_A_IN(PAIR_START_A_IN),
  .PAIR_START_B_IN(PAIR_START_B_IN),
  .PAIR_START_C_IN(PAIR_START_C_IN),
  .STANDBY_N_IN(STANDBY_N_IN),
  .RESET_IN(RESET_IN),
  .WORD_BYTE_SEL_IN(WORD_BYTE_SEL_IN),
  .CS_N_IN(CS_N_IN),
  .DB_OE_OUT(DB_OE_OUT),
  .BUSY_OUT(BUSY_OUT),
  .PAIR_HOLD_OUT(PAIR_HOLD_OUT),
  .PAIR_PWRDN_OUT(PAIR_PWRDN_OUT)
);

// ===== sim/adcc_host.sv
// host model: start pins, strobes, serial clock, data lines
// assumes the block's clock; tasks called by the bench
`timescale 1ns/1ps
module adcc_host (
  input wire logic clk_in,
  input wire logic busy_in,
  input wire logic dout_in,
  input wire logic [15:0] db_in,
  output logic [2:0] start_out,
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic sclk_out,
  output logic [15:0] db_out
);
  // ----------------
  // pin drivers
  // ----------------
  initial begin
    start_out = 3'b111; // high through reset
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    sclk_out = 1'b0;
    db_out = 16'h0000;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic pulse(input logic [2:0] m, input int n);
    for (int i = 0; i < 300 && busy_in; i++) wait_n(1);
    start_out <= start_out & ~m; // fall then rise
    wait_n(n);
    start_out <= start_out | m;
    wait_n(1);
  endtask
  task automatic cs(input logic b);
    cs_n_out <= b;
    wait_n(4);
  endtask
  task automatic rd(output logic [15:0] v);
    rd_n_out <= 1'b0;
    wait_n(5);
    v = db_in;
    rd_n_out <= 1'b1;
    wait_n(5);
  endtask
  task automatic wr(input logic [7:0] b);
    db_out <= {b, 8'h00};
    wr_n_out <= 1'b0;
    wait_n(5);
    wr_n_out <= 1'b1;
    wait_n(4);
    db_out <= ~{b, 8'h00};
  endtask
  task automatic srd(output logic [15:0] v);
    rd_n_out <= 1'b0;
    cs_n_out <= 1'b0;
    wait_n(4);
    for (int i = 0; i < 16; i++) begin
      sclk_out <= 1'b1;
      wait_n(4);
      v = {v[14:0], dout_in}; // output a always enabled
      sclk_out <= 1'b0;
      wait_n(4);
    end
    cs_n_out <= 1'b1;
    wait_n(4);
    rd_n_out <= 1'b1;
    wait_n(4);
  endtask
endmodule

// ===== sim/tb_top.sv
// bench of the converter control block
// assumes the host model and the bound checker
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    n_checks++; \
    if ((got) !== (ex)) begin \
      failures++; \
      $display("MISMATCH %s exp %h got %h", nm, ex, got); \
    end \
  end
module tb_top;
  logic clk, nrst, ce, psel, pen, pwr, pready, pslverr, pd_seen;
  logic standby_n_n, rng, dev_rst, hwsw, ser, wb, bo;
  logic cs_n, rd_n, wr_n, sclk, dout, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] start, hold, pd;
  logic [15:0] hdb, db_out, db_oe;
  wire logic [15:0] db_w = (db_oe & db_out) | (~db_oe & hdb);
  int failures, n_checks;
  // ----------------
  // instances and helpers
  // ----------------
  always #5 clk = ~clk;
  always @(posedge clk) if (pd[1] === 1'b1) pd_seen <= 1'b1;
  adcc_top #(.PD_CYCLES(8)) DUT (
    .SYS_CLK_IN(clk), .NRST_IN(nrst), .CE_IN(ce),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .PAIR_START_A_IN(start[0]), .PAIR_START_B_IN(start[1]),
    .PAIR_START_C_IN(start[2]), .STANDBY_N_IN(standby_n_n), .RANGE_IN(rng),
    .RESET_IN(dev_rst), .HW_SW_SELECT_IN(hwsw), .SERIAL_PARALLEL_SEL_IN(ser),
    .WORD_BYTE_SEL_IN(wb), .BYTE_ORDER_SEL_IN(bo), .CS_N_IN(cs_n),
    .RD_N_IN(rd_n), .WR_N_IN(wr_n), .SCLK_IN(sclk), .DB_IN(db_w),
    .DB_OUT(db_out), .DB_OE_OUT(db_oe), .DOUT_A_OUT(dout), .BUSY_OUT(busy),
    .PAIR_HOLD_OUT(hold), .PAIR_PWRDN_OUT(pd)
  );
  adcc_host u_host (
    .clk_in(clk), .busy_in(busy), .dout_in(dout), .db_in(db_w),
    .start_out(start), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .sclk_out(sclk), .db_out(hdb)
  );
  function automatic logic [15:0] smp(input int k);
    return 16'(16'h9000 + k * 16'h0123);
  endfunction
  function automatic logic [15:0] res(input int k, input logic r);
    return r ? smp(k) : 16'($signed(smp(k)) >>> 1);
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] x, input logic ex);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    `CHK("prdata", x, r)
    `CHK("pslverr", ex, e)
  endtask
  task automatic wait_busy(output int n, output logic [2:0] h);
    n = 0;
    for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
    h = hold;
    while (n < 300 && busy === 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic quiet(input string s);
    logic b;
    b = 1'b0;
    repeat (20) begin
      @(posedge clk);
      b = b | busy;
    end
    `CHK(s, 1'b0, b)
  endtask
  // ----------------
  // scenarios
  // ----------------
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rreg(8'h08, 32'h0000_0020, 1'b0);
    apb(1'b1, 8'h08, 32'h0000_0000, r, e);
    rreg(8'h08, 32'h0000_0001, 1'b0);
    apb(1'b1, 8'h08, 32'h0000_0020, r, e);
    rreg(8'h08, 32'h0000_0020, 1'b0);
    rreg(8'h40, 32'h0000_0000, 1'b1);
    for (int k = 0; k < 6; k++) apb(1'b1, 8'h10 + 8'(4 * k), {16'h0000, smp(k)}, r, e);
    rreg(8'h24, {16'h0000, smp(5)}, 1'b0);
    $display("TB: regs done");
  endtask
  task automatic t_rst();
    for (int r = 0; r < 2; r++) begin
      rng <= r[0];
      u_host.pulse(3'b001, 6);
      u_host.wait_n(10);
      dev_rst <= 1'b1;
      u_host.wait_n(10);
      `CHK("abort", 1'b0, busy)
      dev_rst <= 1'b0;
      u_host.wait_n(4);
      rreg(8'h04, 32'h0000_0000, 1'b0);
      rreg(8'h00, {27'h0, {3{r[0]}}, 2'b00}, 1'b0);
    end
    $display("TB: reset done");
  endtask
  task automatic t_hw();
    int n;
    logic [2:0] h;
    logic [15:0] v;
    rng <= 1'b0;
    u_host.pulse(3'b111, 6);
    wait_busy(n, h);
    `CHK("pairs", 3'b111, h)
    `CHK("busy len", 38, n)
    u_host.cs(1'b0);
    for (int k = 0; k < 6; k++) begin
      u_host.rd(v);
      `CHK("word", smp(k), v)
    end
    u_host.cs(1'b1);
    $display("TB: hw done");
  endtask
  task automatic t_read();
    int n;
    logic [2:0] h;
    logic [15:0] v, x;
    u_host.pulse(3'b111, 6);
    wait_busy(n, h);
    wb <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      bo <= ~k[0];
      x = res(k, 1'b0);
      u_host.cs(1'b0);
      u_host.rd(v);
      `CHK("byte1", k ? x[7:0] : x[15:8], v[15:8])
      u_host.rd(v);
      `CHK("byte2", k ? x[15:8] : x[7:0], v[15:8])
      u_host.cs(1'b1);
    end
    wb <= 1'b0;
    ser <= 1'b1;
    u_host.wait_n(4);
    u_host.srd(v);
    `CHK("serial", res(2, 1'b0), v)
    ser <= 1'b0;
    $display("TB: read done");
  endtask
  task automatic t_sw();
    int n;
    logic [2:0] h;
    logic [15:0] v;
    hwsw <= 1'b1;
    u_host.cs(1'b0);
    u_host.wr(8'h90);
    u_host.cs(1'b1);
    rreg(8'h04, 32'h0000_0090, 1'b0);
    u_host.pulse(3'b001, 6);
    wait_busy(n, h);
    `CHK("sw pairs", 3'b100, h)
    u_host.cs(1'b0);
    for (int k = 0; k < 5; k++) u_host.rd(v);
    u_host.cs(1'b1);
    `CHK("sw range", smp(4), v)
    hwsw <= 1'b0;
    $display("TB: sw done");
  endtask
  task automatic t_ce();
    int n;
    logic [2:0] h;
    u_host.pulse(3'b001, 6);
    for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk);
    ce <= 1'b0;
    u_host.wait_n(10);
    ce <= 1'b1;
    wait_busy(n, h);
    `CHK("ce len", 38, n)
    $display("TB: ce done");
  endtask
  task automatic t_idle();
    standby_n_n <= 1'b0;
    u_host.pulse(3'b001, 6);
    quiet("standby");
    standby_n_n <= 1'b1;
    u_host.pulse(3'b010, 20);
    `CHK("pd", 1'b1, pd_seen)
    quiet("wake");
    $display("TB: idle done");
  endtask
  task automatic end_of_test();
    $display("TB: checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    {nrst, psel, pen, pwr, dev_rst, hwsw, ser, wb, bo, pd_seen} = '0;
    {standby_n_n, rng, ce} = 3'b111;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_rst();
    t_hw();
    t_read();
    t_sw();
    t_ce();
    t_idle();
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule
